// >>> shared/rcs_pkg.sv
// Constants and types for the reset configuration sequencer
package rcs_pkg;
   localparam logic [15:0] RST_CTRL_BASE = 16'hC000;
   localparam logic [11:0] RST_CTRL_FIRST = 12'h000;
   localparam logic [11:0] RST_CTRL_LAST = 12'h012;
   localparam int SEL_W = 4;
   localparam int NUM_SPEED = 3;
   localparam logic [6:0] EE_ADDR_FIRST = 7'h50;
   localparam logic [6:0] EE_ADDR_LAST = 7'h57;
   localparam logic [15:0] EE_OFS_LO = 16'h0000;
   localparam logic [15:0] EE_OFS_HI = 16'hF000;
   localparam logic [1:0] SPD_1M = 2'h0;
   localparam logic [1:0] SPD_400K = 2'h1;
   localparam logic [1:0] SPD_100K = 2'h2;
   localparam int CLK_PERIOD_NS = 4;
   localparam int STRAP_HOLD_NS = 20;
   localparam int STRAP_HOLD_CYC =
      (STRAP_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ERR_OTP = 0;
   localparam int ERR_EE_NONE = 1;
   localparam int ERR_EE_BAD = 2;
   localparam int ERR_NOCFG = 3;
   localparam int ERR_W = 4;
   typedef enum logic [3:0] {
      ST_HELD    = 4'h0,
      ST_LATCH   = 4'h1,
      ST_DEFAULT = 4'h3,
      ST_UPDATE  = 4'h2,
      ST_OTP     = 4'h6,
      ST_EECFG   = 4'h7,
      ST_HOTFIX  = 4'h5,
      ST_PLL     = 4'h4,
      ST_SERIAL  = 4'hC,
      ST_APPLY   = 4'hD,
      ST_MON     = 4'hF,
      ST_DONE    = 4'hE
   } rcs_state_t;
endpackage

// >>> hdl/rcs_top.sv
// Reset and start-up configuration sequencer
module rcs_top #(
   parameter int GPIO_W = 8,
   parameter int NSTRAP = 4
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic master_reset_low,
   input wire logic test_select_low,
   input wire logic [GPIO_W-1:0] gpio_in,
   input wire logic [NSTRAP-1:0] strap_sel_mask,
   input wire logic strap_spi_pin,
   input wire logic strap_ee_en_pin,
   input wire logic factory_done,
   input wire logic pll_cal_done,
   input wire logic pll_locked,
   output logic pll_cal_start,
   output logic pll_relock,
   output logic otp_req,
   output logic [rcs_pkg::SEL_W-1:0] otp_cfg_num,
   input wire logic otp_ack,
   input wire logic otp_found,
   input wire logic otp_csum_ok,
   input wire logic otp_div_prog,
   input wire logic otp_sel_spi,
   input wire logic hotfix_present,
   output logic hotfix_run,
   input wire logic hotfix_ack,
   output logic ee_req,
   output logic ee_upd_mode,
   output logic [6:0] ee_dev_addr,
   output logic [1:0] ee_speed,
   output logic [15:0] ee_offset,
   input wire logic ee_ack,
   input wire logic ee_present,
   input wire logic ee_valid,
   input wire logic ee_sel_spi,
   output logic image_default,
   output logic image_apply,
   output logic clk_out_en,
   output logic gpio_out_en,
   output logic slave_en,
   output logic slave_spi,
   output logic slave_spi_4wire,
   output logic mon_en,
   output logic alarm_en,
   output logic low_power,
   input wire logic [3:0] block_en_req,
   output logic [3:0] block_active,
   output logic seq_done,
   output logic [rcs_pkg::SEL_W-1:0] cfg_loaded_num,
   output logic cfg_otp_loaded,
   output logic cfg_ee_loaded,
   output logic [rcs_pkg::ERR_W-1:0] seq_err,
   output logic [15:0] rst_ctrl_base,
   output logic [11:0] rst_ctrl_last
);
   typedef struct packed {
      rcs_pkg::rcs_state_t st;
      logic mr_prev;
      logic [GPIO_W-1:0] gpio_cap;
      logic [7:0] hold_cnt;
      logic sel_spi;
      logic ee_en;
      logic req;
      logic upd;
      logic [6:0] addr;
      logic [1:0] spd;
      logic ofs_hi;
      logic any_ee;
      logic otp_ok;
      logic ee_ok;
      logic cal_run;
      logic [rcs_pkg::SEL_W-1:0] num;
      logic [rcs_pkg::ERR_W-1:0] err;
      logic pll_go;
      logic relock;
      logic slave;
      logic apply;
      logic outs;
      logic mon;
      logic alarm;
      logic done;
   } rcs_reg_t;

   logic rst_s1_q;
   logic rst_s2_q;
   rcs_reg_t s_q;
   rcs_reg_t s_d;
   logic [rcs_pkg::SEL_W-1:0] sel_val;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   // Strap number from masked captured pins, unused upper bits zero
   always_comb begin
      sel_val = '0;
      for (int i = 0; i < NSTRAP; i++) begin
         if (strap_sel_mask[i] && s_q.gpio_cap[i] && i < rcs_pkg::SEL_W) begin
            sel_val[i] = 1'b1;
         end
      end
   end
   always_comb begin
      s_d = s_q;
      s_d.mr_prev = master_reset_low;
      s_d.pll_go = 1'b0;
      unique case (s_q.st)
         rcs_pkg::ST_HELD: begin
            // Factory block and PLL lock happen while held
            if (!s_q.mr_prev && master_reset_low && test_select_low &&
                factory_done && pll_locked) begin
               s_d.gpio_cap = gpio_in;
               s_d.sel_spi = strap_spi_pin;
               s_d.ee_en = strap_ee_en_pin;
               s_d.hold_cnt = '0;
               s_d.st = rcs_pkg::ST_LATCH;
            end
         end
         rcs_pkg::ST_LATCH: begin
            s_d.hold_cnt = s_q.hold_cnt + 8'h01;
            if (s_q.hold_cnt >= 8'(rcs_pkg::STRAP_HOLD_CYC - 1)) begin
               s_d.st = rcs_pkg::ST_DEFAULT;
            end
         end
         rcs_pkg::ST_DEFAULT: begin
            s_d.st = s_q.ee_en ? rcs_pkg::ST_UPDATE : rcs_pkg::ST_OTP;
            s_d.num = sel_val;
            s_d.addr = rcs_pkg::EE_ADDR_FIRST;
            s_d.spd = rcs_pkg::SPD_1M;
            s_d.ofs_hi = 1'b0;
            s_d.upd = 1'b1;
            s_d.any_ee = 1'b0;
            s_d.req = 1'b0;
         end
         rcs_pkg::ST_UPDATE, rcs_pkg::ST_EECFG: begin
            if (!s_q.req) begin
               s_d.req = 1'b1;
            end else if (ee_ack) begin
               s_d.req = 1'b0;
               s_d.any_ee = s_q.any_ee || ee_present;
               if (ee_present && ee_valid && s_q.upd) begin
                  s_d.st = rcs_pkg::ST_HELD;
               end else if (ee_present && ee_valid) begin
                  s_d.ee_ok = 1'b1;
                  s_d.sel_spi = ee_sel_spi;
                  s_d.st = rcs_pkg::ST_HOTFIX;
               end else begin
                  if (ee_present && !s_q.upd && !s_q.ofs_hi) begin
                     s_d.ofs_hi = 1'b1;
                     s_d.err[rcs_pkg::ERR_EE_BAD] = 1'b1;
                  end else begin
                     s_d.ofs_hi = 1'b0;
                     if (ee_present && !s_q.upd) begin
                        s_d.err[rcs_pkg::ERR_EE_BAD] = 1'b1;
                     end
                     if (s_q.addr != rcs_pkg::EE_ADDR_LAST) begin
                        s_d.addr = s_q.addr + 7'h01;
                     end else if (s_q.spd != rcs_pkg::SPD_100K) begin
                        s_d.addr = rcs_pkg::EE_ADDR_FIRST;
                        s_d.spd = s_q.spd + 2'h1;
                     end else begin
                        s_d.addr = rcs_pkg::EE_ADDR_FIRST;
                        s_d.spd = rcs_pkg::SPD_1M;
                        if (!s_q.any_ee && !s_q.upd) begin
                           s_d.err[rcs_pkg::ERR_EE_NONE] = 1'b1;
                        end
                        s_d.any_ee = 1'b0;
                        s_d.st = s_q.upd ? rcs_pkg::ST_OTP
                                         : rcs_pkg::ST_HOTFIX;
                     end
                  end
               end
            end
         end
         rcs_pkg::ST_OTP: begin
            if (!s_q.req) begin
               s_d.req = 1'b1;
            end else if (otp_ack) begin
               s_d.req = 1'b0;
               s_d.upd = 1'b0;
               if (otp_found && otp_csum_ok) begin
                  s_d.otp_ok = 1'b1;
                  s_d.sel_spi = otp_sel_spi;
                  s_d.pll_go = otp_div_prog;
                  s_d.cal_run = otp_div_prog;
               end else begin
                  s_d.err[rcs_pkg::ERR_OTP] = 1'b1;
               end
               s_d.st = s_q.ee_en ? rcs_pkg::ST_EECFG : rcs_pkg::ST_HOTFIX;
            end
         end
         rcs_pkg::ST_HOTFIX: begin
            if (!hotfix_present) begin
               s_d.st = rcs_pkg::ST_PLL;
            end else if (!s_q.req) begin
               s_d.req = 1'b1;
            end else if (hotfix_ack) begin
               s_d.req = 1'b0;
               s_d.st = rcs_pkg::ST_PLL;
            end
         end
         rcs_pkg::ST_PLL: begin
            s_d.cal_run = s_q.cal_run && !pll_cal_done;
            if (!(s_q.otp_ok || s_q.ee_ok)) begin
               s_d.err[rcs_pkg::ERR_NOCFG] = 1'b1;
               s_d.st = rcs_pkg::ST_SERIAL;
            end else if (!s_q.relock) begin
               s_d.relock = 1'b1;
            end else if (pll_locked && !s_q.cal_run) begin
               s_d.relock = 1'b0;
               s_d.st = rcs_pkg::ST_SERIAL;
            end
         end
         rcs_pkg::ST_SERIAL: begin
            s_d.slave = 1'b1;
            s_d.st = rcs_pkg::ST_APPLY;
         end
         rcs_pkg::ST_APPLY: begin
            s_d.apply = 1'b1;
            s_d.outs = 1'b1;
            s_d.st = rcs_pkg::ST_MON;
         end
         rcs_pkg::ST_MON: begin
            s_d.apply = 1'b0;
            s_d.mon = 1'b1;
            s_d.st = rcs_pkg::ST_DONE;
         end
         rcs_pkg::ST_DONE: begin
            s_d.alarm = 1'b1;
            s_d.done = 1'b1;
         end
         default: s_d.st = rcs_pkg::ST_HELD;
      endcase
      if (!master_reset_low) begin
         s_d = '0;
         s_d.st = rcs_pkg::ST_HELD;
      end
   end
   always_ff @(posedge sys_clk or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   // Default image pulses while defaults are built
   assign image_default = (s_q.st == rcs_pkg::ST_DEFAULT);
   assign image_apply = s_q.apply;
   assign pll_cal_start = s_q.pll_go;
   assign pll_relock = s_q.relock;
   assign otp_req = s_q.req && (s_q.st == rcs_pkg::ST_OTP);
   assign otp_cfg_num = s_q.num;
   assign hotfix_run = s_q.req && (s_q.st == rcs_pkg::ST_HOTFIX);
   assign ee_req = s_q.req && (s_q.st == rcs_pkg::ST_UPDATE ||
                               s_q.st == rcs_pkg::ST_EECFG);
   assign ee_upd_mode = s_q.upd;
   assign ee_dev_addr = s_q.addr;
   assign ee_speed = s_q.spd;
   assign ee_offset = s_q.ofs_hi ? rcs_pkg::EE_OFS_HI
                                 : rcs_pkg::EE_OFS_LO;
   assign clk_out_en = s_q.outs;
   assign gpio_out_en = s_q.outs;
   assign slave_en = s_q.slave && s_q.done;
   assign slave_spi = s_q.sel_spi;
   assign slave_spi_4wire = s_q.sel_spi;
   assign mon_en = s_q.mon;
   assign alarm_en = s_q.alarm;
   // Blocks run only when requested after start-up
   assign low_power = !s_q.done;
   assign block_active = s_q.done ? block_en_req : 4'h0;
   assign seq_done = s_q.done;
   assign cfg_loaded_num = s_q.otp_ok ? s_q.num : '0;
   assign cfg_otp_loaded = s_q.otp_ok;
   assign cfg_ee_loaded = s_q.ee_ok;
   assign seq_err = s_q.err;
   assign rst_ctrl_base = rcs_pkg::RST_CTRL_BASE;
   assign rst_ctrl_last = rcs_pkg::RST_CTRL_LAST;
   property p_done_blocks_slave;
      @(posedge sys_clk) disable iff (!rst_s2_q)
         slave_en |-> seq_done;
   endproperty
   a_done_blocks_slave: assert property (p_done_blocks_slave)
      else $error("slave enabled before done");
   property p_reset_quiet;
      @(posedge sys_clk) disable iff (!rst_s2_q)
         !master_reset_low |=> !clk_out_en && !gpio_out_en && !slave_en;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs active under reset");
   sequence s_apply;
      image_apply ##1 mon_en;
   endsequence
   property p_order;
      @(posedge sys_clk) disable iff (!rst_s2_q)
         $rose(image_apply) |-> s_apply ##1 alarm_en;
   endproperty
   a_order: assert property (p_order)
      else $error("completion order wrong");
   property p_ofs;
      @(posedge sys_clk) disable iff (!rst_s2_q)
         ee_offset == rcs_pkg::EE_OFS_LO || ee_offset == rcs_pkg::EE_OFS_HI;
   endproperty
   a_ofs: assert property (p_ofs)
      else $error("bad eeprom offset");
   property p_addr;
      @(posedge sys_clk) disable iff (!rst_s2_q)
         ee_req |-> ee_dev_addr >= rcs_pkg::EE_ADDR_FIRST &&
                    ee_dev_addr <= rcs_pkg::EE_ADDR_LAST;
   endproperty
   a_addr: assert property (p_addr)
      else $error("eeprom address out of range");
   property p_nocfg;
      @(posedge sys_clk) disable iff (!rst_s2_q)
         $rose(seq_done) && !cfg_otp_loaded && !cfg_ee_loaded
            |-> seq_err[rcs_pkg::ERR_NOCFG];
   endproperty
   a_nocfg: assert property (p_nocfg)
      else $error("missing no-config status");
   property p_start;
      @(posedge sys_clk) disable iff (!rst_s2_q)
         $rose(master_reset_low) && !test_select_low |=> (!image_default) [*8];
   endproperty
   a_start: assert property (p_start)
      else $error("sequence started in test mode");
   property p_power;
      @(posedge sys_clk) disable iff (!rst_s2_q)
         !seq_done |-> block_active == 4'h0 && low_power;
   endproperty
   a_power: assert property (p_power)
      else $error("blocks active before done");
endmodule

// >>> test/rcs_far_model.sv
// Far-side responders for OTP, hotfix and EEPROM requests
module rcs_far_model (
   input wire logic sys_clk,
   input wire logic otp_req,
   input wire logic hotfix_run,
   input wire logic ee_req,
   input wire logic ee_upd_mode,
   input wire logic [6:0] ee_dev_addr,
   input wire logic [1:0] ee_speed,
   input wire logic [15:0] ee_offset,
   input wire logic [7:0] dly,
   input wire logic [6:0] pres_addr,
   input wire logic [1:0] pres_spd,
   input wire logic upd_ok,
   input wire logic [1:0] cfg_ok,
   output logic otp_ack,
   output logic hotfix_ack,
   output logic ee_ack,
   output logic ee_present,
   output logic ee_valid,
   output logic ee_sel_spi
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] req;
   logic [2:0] ack = 3'h0;
   logic [7:0] cnt [3] = '{8'h00, 8'h00, 8'h00};
   logic hit;
   assign req = {ee_req, hotfix_run, otp_req};
   assign {ee_ack, hotfix_ack, otp_ack} = ack;
   assign hit = ee_dev_addr == pres_addr && ee_speed == pres_spd;
   initial begin
      ee_present = 1'b0;
      ee_valid = 1'b1;
      ee_sel_spi = 1'b0;
   end
   always @(posedge sys_clk) begin
      for (int i = 0; i < 3; i++) begin
         if (req[i] !== 1'b1 || ack[i]) begin
            ack[i] <= 1'b0;
            cnt[i] <= 8'h00;
         end else if (cnt[i] >= dly) begin
            ack[i] <= 1'b1;
         end else begin
            cnt[i] <= cnt[i] + 8'h01;
         end
      end
      // Stored blocks are whole images of what they set
      if (ee_req === 1'b1 && !ack[2] && cnt[2] >= dly) begin
         ee_present <= hit;
         ee_valid <= hit && (ee_upd_mode ? upd_ok :
            (ee_offset == rcs_pkg::EE_OFS_HI ? cfg_ok[1] : cfg_ok[0]));
         ee_sel_spi <= 1'b0;
      end else begin
         ee_present <= ~ee_present;
         ee_valid <= ~ee_valid;
         ee_sel_spi <= ~ee_sel_spi;
      end
   end
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the reset configuration sequencer
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 0, rst_b = 0, master_reset_low = 0, test_select_low = 1;
   logic [7:0] gpio_in = 8'h00;
   logic [3:0] strap_sel_mask = 4'h3, block_en_req = 4'h0;
   logic strap_spi_pin = 0, strap_ee_en_pin = 0, factory_done = 1;
   logic pll_cal_done = 1, pll_locked = 1, otp_found = 0, otp_csum_ok = 0;
   logic otp_div_prog = 0, otp_sel_spi = 0, hotfix_present = 0;
   logic [7:0] dly = 8'h02;
   logic [6:0] pres_addr = 7'h00;
   logic [1:0] pres_spd = 2'h0, cfg_ok = 2'h0;
   logic upd_ok = 0;
   logic pll_cal_start, pll_relock, otp_req, hotfix_run, ee_req, ee_upd_mode;
   logic [3:0] otp_cfg_num, block_active, cfg_loaded_num, seq_err;
   logic [6:0] ee_dev_addr;
   logic [1:0] ee_speed;
   logic [15:0] ee_offset, rst_ctrl_base;
   logic [11:0] rst_ctrl_last;
   logic image_default, image_apply, clk_out_en, gpio_out_en, slave_en;
   logic slave_spi, slave_spi_4wire, mon_en, alarm_en, low_power, seq_done;
   logic cfg_otp_loaded, cfg_ee_loaded, otp_ack, hotfix_ack, ee_ack;
   logic ee_present, ee_valid, ee_sel_spi;
   int miscompares = 0, samples_checked = 0, cyc = 0;
   int t_ev [12];
   logic [25:0] ee_log [$];
   logic [3:0] otp_num_seen;
   logic [11:0] mon_v;
   rcs_top #(.GPIO_W(8), .NSTRAP(4)) rcs_top_inst (.*);
   rcs_far_model rcs_far_model_inst (.*);
   always #2 sys_clk = ~sys_clk;
   // Event index: 0 dflt 1 otp 2 ee 3 hotfix 4 relock 5 apply 6 clk
   // 7 mon 8 alarm 9 slave 10 done 11 cal
   assign mon_v = {pll_cal_start, seq_done, slave_en, alarm_en, mon_en,
      clk_out_en, image_apply, pll_relock, hotfix_run, ee_req, otp_req,
      image_default};
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      for (int i = 0; i < 12; i++)
         if (mon_v[i] === 1'b1 && t_ev[i] < 0) t_ev[i] = cyc;
      if (ee_req === 1'b1 && ee_ack === 1'b1)
         ee_log.push_back({ee_upd_mode, ee_speed, ee_dev_addr, ee_offset});
      if (otp_req === 1'b1 && otp_ack === 1'b1) otp_num_seen = otp_cfg_num;
   end
   task automatic check(input string what, input logic [31:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic close_out;
      if (miscompares == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic start(input logic ee_en, spi, input logic [7:0] g);
      @(posedge sys_clk);
      master_reset_low <= 1'b0;
      gpio_in <= g;
      strap_ee_en_pin <= ee_en;
      strap_spi_pin <= spi;
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      check("held", {clk_out_en, gpio_out_en, slave_en, seq_done}, 0);
      foreach (t_ev[i]) t_ev[i] = -1;
      ee_log.delete();
      repeat (4) @(posedge sys_clk);
      master_reset_low <= 1'b1; // Low for 6 cycles, over 20 ns
      repeat (2) @(posedge sys_clk);
      gpio_in <= ~g;
   endtask
   task automatic wait_done(input int lim);
      int n;
      n = 0;
      while (seq_done !== 1'b1 && n < lim) begin
         @(posedge sys_clk);
         n++;
      end
      @(negedge sys_clk);
      check("seq_done", seq_done, 1'b1);
      check("slave_with_done", t_ev[9] == t_ev[10], 1'b1);
   endtask
   task automatic t_idle;
      @(negedge sys_clk);
      check("base", rst_ctrl_base, rcs_pkg::RST_CTRL_BASE);
      check("last", rst_ctrl_last, 12'h012);
      check("low_power", low_power, 1'b1);
      check("block_idle", block_active, 4'h0);
   endtask
   task automatic t_test_low;
      @(posedge sys_clk);
      test_select_low <= 1'b0;
      start(1'b0, 1'b0, 8'h00);
      repeat (40) @(posedge sys_clk);
      check("no_default", t_ev[0], -1);
      check("no_otp", t_ev[1], -1);
      {test_select_low, factory_done} <= 2'h2;
      start(1'b0, 1'b0, 8'h00);
      repeat (20) @(posedge sys_clk);
      check("no_factory", t_ev[0], -1);
      {factory_done, pll_locked} <= 2'h2;
      start(1'b0, 1'b0, 8'h00);
      repeat (20) @(posedge sys_clk);
      check("no_lock", t_ev[0], -1);
      pll_locked <= 1'b1;
   endtask
   task automatic t_otp_ok;
      int pa [6] = '{0, 1, 3, 4, 5, 7};
      int pb [6] = '{1, 3, 4, 5, 7, 8};
      {otp_found, otp_csum_ok, otp_div_prog, otp_sel_spi} <= 4'hF;
      hotfix_present <= 1'b1;
      block_en_req <= 4'h5;
      pll_cal_done <= 1'b0;
      start(1'b0, 1'b0, 8'hA6);
      while (pll_relock !== 1'b1) @(posedge sys_clk);
      repeat (10) @(posedge sys_clk);
      check("cal_wait", seq_done, 1'b0);
      pll_cal_done <= 1'b1;
      wait_done(600);
      check("otp_num", otp_num_seen, 4'h2);
      check("loaded_num", cfg_loaded_num, 4'h2);
      check("otp_loaded", cfg_otp_loaded, 1'b1);
      check("cal_start", t_ev[11] >= 0, 1'b1);
      check("slave_spi", slave_spi, 1'b1);
      check("outs_on", {clk_out_en, mon_en, alarm_en}, 3'h7);
      check("err_otp", {seq_err[0], seq_err[3]}, 2'h0);
      check("blocks", {low_power, block_active}, 5'h05);
      for (int i = 0; i < 6; i++)
         check("order", t_ev[pa[i]] >= 0 && t_ev[pa[i]] < t_ev[pb[i]],
            1'b1);
      @(posedge sys_clk);
      block_en_req <= 4'h0;
      hotfix_present <= 1'b0;
   endtask
   task automatic t_ee_cfg;
      int k;
      logic [25:0] e;
      @(posedge sys_clk);
      otp_found <= 1'b0; // No valid OTP config behind EEPROM use
      {dly, pres_addr, pres_spd, cfg_ok} <= {8'h00, 7'h53, 2'h1, 2'h2};
      start(1'b1, 1'b0, 8'h03);
      repeat (20) @(posedge sys_clk);
      start(1'b1, 1'b0, 8'h03);
      wait_done(3000);
      check("errs", seq_err, 4'h5);
      check("ee_loaded", {cfg_ee_loaded, cfg_otp_loaded}, 2'h2);
      check("relock", t_ev[4] >= 0, 1'b1);
      check("ee_count", ee_log.size() >= 10, 1'b1);
      if (ee_log.size() >= 10) begin
         check("first", ee_log[0], {1'b1, 2'h0, 7'h50, 16'h0000});
         check("cfg_lo", ee_log[$-1][22:0], {7'h53, 16'h0000});
         check("cfg_hi", ee_log[$][22:0], {7'h53, 16'hF000});
      end
      k = 0;
      foreach (ee_log[i]) begin
         e = ee_log[i];
         if (k == 0 && e[24:23] == rcs_pkg::SPD_400K) k = i;
         check("ee_addr", e[22:16] >= 7'h50 && e[22:16] <= 7'h57, 1);
         check("ee_ofs", e[15:0] == 0 || (e[15:0] == 16'hF000 && !e[25]),
            1'b1);
      end
      check("speed_step", k > 0, 1'b1);
      if (k > 0) check("prev", ee_log[k-1][24:16], {2'h0, 7'h57});
   endtask
   task automatic t_upd;
      @(posedge sys_clk);
      {pres_addr, pres_spd, upd_ok} <= {7'h50, 2'h0, 1'b1};
      start(1'b1, 1'b0, 8'h00);
      repeat (60) @(posedge sys_clk);
      check("upd_no_otp", t_ev[1], -1);
      check("upd_one", ee_log.size(), 1);
      if (ee_log.size() > 0) check("upd_mode", ee_log[0][25], 1'b1);
      {pres_addr, upd_ok, dly} <= {7'h00, 1'b0, 8'h01};
      start(1'b1, 1'b1, 8'h00);
      wait_done(3000);
      check("nocfg_errs", seq_err, 4'hB);
      check("no_relock", t_ev[4], -1);
      check("spi4", {slave_spi, slave_spi_4wire}, 2'h3);
   endtask
   initial begin
      #100000;
      miscompares++;
      close_out();
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge sys_clk);
      t_idle();
      t_test_low();
      t_otp_ok();
      t_ee_cfg();
      t_upd();
      close_out();
   end
endmodule
